// ---- design/rrse_exec.sv ----
// execution of literal return, return, rotates through carry and sleep
// Summary of operation
// - literal return loads 8-bit literal into accumulator
// - literal return reloads pc from stack top, two cycles
// - plain return pops stack into pc, two cycles
// - left rotate of file register through carry
// - left rotate destination: 0 accumulator, 1 file
// - right rotate of file register through carry
// - right rotate destination: 0 accumulator, 1 file
// - sleep clears the power-down flag
// - sleep sets the expiry flag, leaves carry unchanged
// - sleep zeroes watchdog counter and its prescaler
`timescale 1ns/1ps
`default_nettype none
`include "rrse_regs.svh"

module rrse_exec (
   input wire logic clk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire rrse_pkg::rrse_op_t instr_op,
   input wire logic [7:0] instr_literal,
   input wire logic [6:0] instr_file_addr,
   input wire logic instr_dest,
   input wire logic [7:0] file_rdata,
   input wire logic [12:0] stack_top,
   input wire logic wake_event,
   input wire logic watchdog_enable,
   output logic instr_ready,
   output logic [7:0] acc,
   output logic carry,
   output logic [12:0] pc,
   output logic file_wr_en,
   output logic [6:0] file_wr_addr,
   output logic [7:0] file_wr_data,
   output logic stack_pop,
   output logic power_down_flag,
   output logic expiry_flag,
   output logic [7:0] watchdog_counter,
   output logic [7:0] watchdog_prescaler,
   output logic asleep
);

   rrse_pkg::rrse_state_t state_reg;
   rrse_pkg::rrse_state_t state_next;
   logic ready_reg;
   logic asleep_reg;
   logic [7:0] acc_reg;
   logic carry_reg;
   logic [12:0] pc_reg;
   logic file_wr_en_reg;
   logic [6:0] file_wr_addr_reg;
   logic [7:0] file_wr_data_reg;
   logic stack_pop_reg;
   logic pdn_reg;
   logic exp_reg;
   logic [7:0] wdog_reg;
   logic [7:0] presc_reg;
   logic accept;
   logic is_ret;
   logic is_rot;
   logic is_sleep;

   rrse_rot_if rot ();

   rrse_rotate u_rotate (
      .rot(rot.unit)
   );

   // decode of the instruction offered this cycle
   assign accept = instr_valid && ready_reg;
   assign is_ret = (instr_op == rrse_pkg::RRSE_OP_RET_LIT) ||
                   (instr_op == rrse_pkg::RRSE_OP_RETURN);
   assign is_rot = (instr_op == rrse_pkg::RRSE_OP_ROT_LEFT) ||
                   (instr_op == rrse_pkg::RRSE_OP_ROT_RIGHT);
   assign is_sleep = (instr_op == rrse_pkg::RRSE_OP_SLEEP);

   // rotate operand is the addressed file byte, read in the accept cycle
   assign rot.operand = file_rdata;
   assign rot.carry_in = carry_reg;
   assign rot.dir_left = (instr_op == rrse_pkg::RRSE_OP_ROT_LEFT);

   // sequencer: returns spend a second dead cycle, sleep parks the core
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         rrse_pkg::RRSE_ST_RUN: begin
            if (accept && is_ret) begin
               state_next = rrse_pkg::RRSE_ST_SECOND;
            end else if (accept && is_sleep) begin
               state_next = rrse_pkg::RRSE_ST_ASLEEP;
            end
         end
         rrse_pkg::RRSE_ST_SECOND: begin
            state_next = rrse_pkg::RRSE_ST_RUN;
         end
         rrse_pkg::RRSE_ST_ASLEEP: begin
            if (wake_event) begin
               state_next = rrse_pkg::RRSE_ST_RUN;
            end
         end
         default: begin
            state_next = rrse_pkg::RRSE_ST_RUN; // unused code recovers
         end
      endcase
   end

   // state and ready; ready is registered so it stays a clean flop output
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= rrse_pkg::RRSE_ST_RUN;
         ready_reg <= 1'b1;
         asleep_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         ready_reg <= (state_next == rrse_pkg::RRSE_ST_RUN);
         asleep_reg <= (state_next == rrse_pkg::RRSE_ST_ASLEEP);
      end
   end

   // accumulator: literal from a literal return, result of a rotate to w
   always_ff @(posedge clk) begin
      if (srst) begin
         acc_reg <= `RRSE_ACC_RST;
      end else if (accept && instr_op == rrse_pkg::RRSE_OP_RET_LIT) begin
         acc_reg <= instr_literal;
      end else if (accept && is_rot && !instr_dest) begin
         acc_reg <= rot.result;
      end
   end

   // carry is the only status flag a rotate touches
   always_ff @(posedge clk) begin
      if (srst) begin
         carry_reg <= `RRSE_CARRY_RST;
      end else if (accept && is_rot) begin
         carry_reg <= rot.carry_out;
      end
   end

   // write-back strobe toward the file registers, one cycle wide
   always_ff @(posedge clk) begin
      if (srst) begin
         file_wr_en_reg <= 1'b0;
         file_wr_addr_reg <= 7'h00;
         file_wr_data_reg <= 8'h00;
      end else begin
         file_wr_en_reg <= accept && is_rot && instr_dest;
         if (accept && is_rot && instr_dest) begin
            file_wr_addr_reg <= instr_file_addr;
            file_wr_data_reg <= rot.result;
         end
      end
   end

   // program counter and stack pop; both returns pop the return address
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_reg <= `RRSE_PC_RST;
         stack_pop_reg <= 1'b0;
      end else begin
         stack_pop_reg <= accept && is_ret;
         if (accept && is_ret) begin
            pc_reg <= stack_top;
         end else if (accept && (is_rot || is_sleep)) begin
            pc_reg <= pc_reg + 13'h0001; // wake resumes after the sleep
         end
      end
   end

   // power status: device reset sets both, sleep clears one, sets other
   always_ff @(posedge clk) begin
      if (srst) begin
         pdn_reg <= `RRSE_PDN_RST;
         exp_reg <= `RRSE_EXP_RST;
      end else if (accept && is_sleep) begin
         pdn_reg <= 1'b0;
         exp_reg <= 1'b1;
      end
   end

   // watchdog keeps running in sleep; sleep clear outranks counting
   always_ff @(posedge clk) begin
      if (srst) begin
         presc_reg <= `RRSE_PRESC_RST;
         wdog_reg <= `RRSE_WDOG_RST;
      end else if (accept && is_sleep) begin
         presc_reg <= 8'h00;
         wdog_reg <= 8'h00;
      end else if (watchdog_enable) begin
         presc_reg <= presc_reg + 8'h01;
         if (presc_reg == `RRSE_PRESC_MAX) begin
            wdog_reg <= wdog_reg + 8'h01; // wraps, overflow action is outside
         end
      end
   end

   assign instr_ready = ready_reg;
   assign acc = acc_reg;
   assign carry = carry_reg;
   assign pc = pc_reg;
   assign file_wr_en = file_wr_en_reg;
   assign file_wr_addr = file_wr_addr_reg;
   assign file_wr_data = file_wr_data_reg;
   assign stack_pop = stack_pop_reg;
   assign power_down_flag = pdn_reg;
   assign expiry_flag = exp_reg;
   assign watchdog_counter = wdog_reg;
   assign watchdog_prescaler = presc_reg;
   assign asleep = asleep_reg;

   // checks on the executed instructions
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence ret_taken_s;
      accept && is_ret;
   endsequence

   sequence ret_busy_s;
      !instr_ready ##1 instr_ready;
   endsequence

   ret_lit_acc_a: assert property (accept && instr_op == rrse_pkg::RRSE_OP_RET_LIT
      |=> acc == $past(instr_literal)) else $error("literal not loaded into accumulator");
   ret_lit_pc_a: assert property (accept && instr_op == rrse_pkg::RRSE_OP_RET_LIT
      |=> pc == $past(stack_top)) else $error("literal return pc not from stack top");
   ret_two_cycle_a: assert property (ret_taken_s |=> ret_busy_s)
      else $error("return did not take two cycles");
   ret_pop_a: assert property (accept && instr_op == rrse_pkg::RRSE_OP_RETURN
      |=> stack_pop && pc == $past(stack_top) ##1 !stack_pop) else $error("return pop wrong");
   rot_left_file_a: assert property (accept && instr_op == rrse_pkg::RRSE_OP_ROT_LEFT
      && instr_dest |=> file_wr_en && file_wr_addr == $past(instr_file_addr)
      && file_wr_data == {$past(file_rdata[6:0]), $past(carry)})
      else $error("left rotate write-back wrong");
   rot_left_carry_a: assert property (accept && instr_op == rrse_pkg::RRSE_OP_ROT_LEFT
      |=> carry == $past(file_rdata[7]) && $stable(power_down_flag))
      else $error("left rotate carry wrong");
   rot_right_acc_a: assert property (accept && instr_op == rrse_pkg::RRSE_OP_ROT_RIGHT
      && !instr_dest |=> !file_wr_en && acc == {$past(carry), $past(file_rdata[7:1])}
      && carry == $past(file_rdata[0])) else $error("right rotate to accumulator wrong");
   sleep_flags_a: assert property (accept && is_sleep
      |=> !power_down_flag && expiry_flag && $stable(carry)) else $error("sleep flags wrong");
   sleep_watchdog_a: assert property (accept && is_sleep
      |=> watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
      else $error("sleep did not clear watchdog");
   sleep_halt_a: assert property (accept && is_sleep ##1 !wake_event
      |=> !instr_ready && $stable(pc) && $stable(acc)) else $error("core ran during sleep");

endmodule // rrse_exec

`default_nettype wire

// ---- design/rrse_regs.svh ----
// constants for the return, rotate and sleep execution block
`ifndef RRSE_REGS_SVH
`define RRSE_REGS_SVH

// data path widths
`define RRSE_DATA_W 8
`define RRSE_ADDR_W 7
`define RRSE_PC_W 13
// bit positions inside a data byte
`define RRSE_MSB 7
`define RRSE_LSB 0
// reset values
`define RRSE_ACC_RST 8'h00
`define RRSE_PC_RST 13'h0000
`define RRSE_CARRY_RST 1'b0
`define RRSE_PDN_RST 1'b1
`define RRSE_EXP_RST 1'b1
`define RRSE_WDOG_RST 8'h00
`define RRSE_PRESC_RST 8'h00
// watchdog prescaler terminal count
`define RRSE_PRESC_MAX 8'hff
// instruction cycles taken by the two-cycle returns
`define RRSE_RET_CYCLES 2

`endif

// ---- design/rrse_pkg.sv ----
// types shared by the return, rotate and sleep execution block
`default_nettype none

package rrse_pkg;

   // instructions handled by this block
   typedef enum logic [2:0] {
      RRSE_OP_NONE,
      RRSE_OP_RET_LIT,
      RRSE_OP_RETURN,
      RRSE_OP_ROT_LEFT,
      RRSE_OP_ROT_RIGHT,
      RRSE_OP_SLEEP
   } rrse_op_t;

   // sequencer states
   typedef enum logic [1:0] {
      RRSE_ST_RUN,
      RRSE_ST_SECOND,
      RRSE_ST_ASLEEP
   } rrse_state_t;

endpackage

`default_nettype wire

// ---- design/rrse_rot_if.sv ----
// carrier between the sequencer and the rotate unit
`timescale 1ns/1ps
`default_nettype none

interface rrse_rot_if;
   logic [7:0] operand;
   logic carry_in;
   logic dir_left;
   logic [7:0] result;
   logic carry_out;

   modport user (output operand, output carry_in, output dir_left,
                 input result, input carry_out);
   modport unit (input operand, input carry_in, input dir_left,
                 output result, output carry_out);
endinterface // rrse_rot_if

`default_nettype wire

// ---- design/rrse_rotate.sv ----
// rotate-through-carry unit, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "rrse_regs.svh"

module rrse_rotate (
   rrse_rot_if.unit rot
);

   // one function covers both directions, 9-bit ring of byte and carry
   function automatic logic [8:0] rrse_rot9(input logic [7:0] val, input logic cin,
                                            input logic left);
      logic [8:0] res;
      if (left) begin
         res = {val[`RRSE_MSB], val[`RRSE_MSB-1:`RRSE_LSB], cin};
      end else begin
         res = {val[`RRSE_LSB], cin, val[`RRSE_MSB:`RRSE_LSB+1]};
      end
      return res;
   endfunction

   // carry out on top, rotated byte below
   assign {rot.carry_out, rot.result} = rrse_rot9(rot.operand, rot.carry_in, rot.dir_left);

endmodule // rrse_rotate

`default_nettype wire

// ---- dv/rrse_exec_bench.sv ----
// self-checking bench for the return, rotate and sleep execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end

module rrse_exec_bench;
   typedef struct packed {
      logic [7:0] acc; logic carry; logic [12:0] pc; logic [6:0] wa; logic [7:0] wd;
      logic wr_en; logic pop; logic ready; logic pdn; logic asl; logic slp;
   } rrse_note_t;
   logic clk, srst, instr_valid, instr_dest, wake_event, watchdog_enable;
   rrse_pkg::rrse_op_t instr_op;
   logic [7:0] instr_literal, file_rdata, acc, file_wr_data, watchdog_counter, watchdog_prescaler;
   logic [6:0] instr_file_addr, file_wr_addr;
   logic [12:0] stack_top, pc;
   logic instr_ready, carry, file_wr_en, stack_pop, power_down_flag, expiry_flag, asleep;
   logic [7:0] m_acc, m_wd;
   logic [6:0] m_wa;
   logic [12:0] m_pc;
   logic m_carry, m_pdn, took, rnd_wdog;
   logic [15:0] m_wdog;
   rrse_note_t notes[$];
   rrse_note_t n;
   integer seed = 32'hfc23a11d;
   int miscompares = 0;
   int checked = 0;

   rrse_exec dut_u (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr_op(instr_op),
      .instr_literal(instr_literal), .instr_file_addr(instr_file_addr),
      .instr_dest(instr_dest), .file_rdata(file_rdata), .stack_top(stack_top),
      .wake_event(wake_event), .watchdog_enable(watchdog_enable), .instr_ready(instr_ready),
      .acc(acc), .carry(carry), .pc(pc), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
      .file_wr_data(file_wr_data), .stack_pop(stack_pop), .power_down_flag(power_down_flag),
      .expiry_flag(expiry_flag), .watchdog_counter(watchdog_counter),
      .watchdog_prescaler(watchdog_prescaler), .asleep(asleep));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic finish_test;
      begin
         $display("checked %0d miscompares %0d", checked, miscompares);
         if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask

   // reset held three cycles, values checked while it is still applied
   task automatic do_reset;
      begin
         @(negedge clk);
         srst = 1'b1;
         instr_valid = 1'b0;
         repeat (3) @(negedge clk);
         `CHK("reset", {8'h00, 1'b0, 13'h0000, 2'b11, 16'h0000, 4'b0100, 15'h0000},
            {acc, carry, pc, power_down_flag, expiry_flag, watchdog_counter, watchdog_prescaler,
             asleep, instr_ready, file_wr_en, stack_pop, file_wr_addr, file_wr_data})
         srst = 1'b0;
         {m_acc, m_wd, m_wa, m_pc, m_carry, m_pdn} = {37'h0, 1'b1};
         notes.delete();
      end
   endtask

   // offer one instruction, note the expected state one cycle after it is taken
   task automatic issue(input rrse_pkg::rrse_op_t op, input logic [7:0] lit,
      input logic [6:0] a, input logic d, input logic [7:0] fd, input logic [12:0] top);
      rrse_note_t e;
      logic [7:0] res;
      logic nc;
      begin
         @(negedge clk);
         instr_op = op;
         {instr_valid, instr_literal, instr_file_addr} = {1'b1, lit, a};
         {instr_dest, file_rdata, stack_top} = {d, fd, top};
         watchdog_enable = rnd_wdog ? 1'($random(seed)) : 1'b1;
         e = '0;
         e.ready = 1'b1;
         {nc, res} = {fd, m_carry};
         if (op == rrse_pkg::RRSE_OP_ROT_RIGHT)
            {res, nc} = {m_carry, fd};
         case (op)
            rrse_pkg::RRSE_OP_RET_LIT, rrse_pkg::RRSE_OP_RETURN: begin
               if (op == rrse_pkg::RRSE_OP_RET_LIT)
                  m_acc = lit;
               m_pc = top;
               {e.pop, e.ready} = 2'b10;
            end
            rrse_pkg::RRSE_OP_ROT_LEFT, rrse_pkg::RRSE_OP_ROT_RIGHT: begin
               m_carry = nc;
               m_pc = m_pc + 13'h0001;
               if (d)
                  {m_wa, m_wd, e.wr_en} = {a, res, 1'b1};
               else
                  m_acc = res;
            end
            rrse_pkg::RRSE_OP_SLEEP: begin
               m_pdn = 1'b0;
               m_pc = m_pc + 13'h0001;
               {e.ready, e.asl, e.slp} = 3'b011;
            end
            default: ;
         endcase
         {e.acc, e.carry, e.pc, e.wa, e.wd, e.pdn} = {m_acc, m_carry, m_pc, m_wa, m_wd, m_pdn};
         notes.push_back(e);
         @(posedge clk);
         // a rotate offered in the dead cycle of a return must be ignored
         if (e.pop) begin
            @(negedge clk);
            instr_op = rrse_pkg::RRSE_OP_ROT_LEFT;
            instr_dest = 1'b1;
            @(posedge clk);
         end
      end
   endtask

   // watcher: a take is registered here, its result checked at the next falling edge
   always @(posedge clk) begin
      took <= instr_valid && instr_ready && !srst;
   end
   // prescaler and counter behave as one 16-bit count; reset or a taken sleep zero it
   always @(posedge clk) begin
      if (srst || (instr_valid && instr_ready && instr_op == rrse_pkg::RRSE_OP_SLEEP)) begin
         m_wdog <= 16'h0000;
      end else begin
         m_wdog <= m_wdog + {15'h0000, watchdog_enable};
      end
   end
   always @(negedge clk) begin
      if (took && notes.size() == 0) begin
         miscompares++;
         $display("wrong value take expected 0 seen 1");
      end else if (took) begin
         n = notes.pop_front();
         `CHK("acc", n.acc, acc)
         `CHK("carry", n.carry, carry)
         `CHK("pc", n.pc, pc)
         `CHK("pulses", {n.wr_en, n.pop, n.ready}, {file_wr_en, stack_pop, instr_ready})
         `CHK("write", {n.wa, n.wd}, {file_wr_addr, file_wr_data})
         `CHK("flags", {n.pdn, 1'b1, n.asl}, {power_down_flag, expiry_flag, asleep})
         if (n.slp)
            `CHK("watchdog", 16'h0000, {watchdog_counter, watchdog_prescaler})
      end else if (!srst) begin
         `CHK("idle pulses", 2'b00, {file_wr_en, stack_pop})
      end
      if (!srst)
         `CHK("watchdog count", m_wdog, {watchdog_counter, watchdog_prescaler})
   end

   // hang guard, well beyond the roughly 700 cycles of stimulus
   initial begin
      #100000;
      miscompares++;
      $display("wrong value timeout expected done seen hang");
      finish_test();
   end

   initial begin
      instr_op = rrse_pkg::RRSE_OP_NONE;
      {srst, instr_valid, instr_literal, instr_file_addr} = {2'b10, 15'h0000};
      {instr_dest, file_rdata, stack_top, wake_event} = {1'b0, 8'h00, 13'h0000, 1'b0};
      {watchdog_enable, rnd_wdog} = 2'b10;
      do_reset();
      // corners: literal extremes, address 0 and 127, bit 7 and bit 0 through carry
      issue(rrse_pkg::RRSE_OP_NONE, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      issue(rrse_pkg::RRSE_OP_RET_LIT, 8'hff, 7'h00, 1'b0, 8'h00, 13'h1fff);
      issue(rrse_pkg::RRSE_OP_RET_LIT, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      issue(rrse_pkg::RRSE_OP_RETURN, 8'h5a, 7'h00, 1'b0, 8'h00, 13'h0abc);
      issue(rrse_pkg::RRSE_OP_ROT_LEFT, 8'h00, 7'h7f, 1'b1, 8'he6, 13'h0000);
      issue(rrse_pkg::RRSE_OP_ROT_LEFT, 8'h00, 7'h00, 1'b0, 8'h80, 13'h0000);
      issue(rrse_pkg::RRSE_OP_ROT_RIGHT, 8'h00, 7'h7f, 1'b0, 8'h01, 13'h0000);
      issue(rrse_pkg::RRSE_OP_ROT_RIGHT, 8'h00, 7'h40, 1'b1, 8'h00, 13'h0000);
      $display("test corners done");
      // random mix without sleep so the core stays awake
      rnd_wdog = 1'b1;
      repeat (300)
         issue(rrse_pkg::rrse_op_t'(3'($unsigned($random(seed)) % 5)), 8'($random(seed)),
            7'($random(seed)), 1'($random(seed)), 8'($random(seed)), 13'($random(seed)));
      rnd_wdog = 1'b0;
      $display("test random done");
      // idle stretch with the watchdog on, so the counter has moved before sleep clears it
      repeat (260)
         issue(rrse_pkg::RRSE_OP_NONE, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      // sleep parks the core; offers while parked are ignored until wake
      issue(rrse_pkg::RRSE_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00, 13'h0000);
      @(negedge clk);
      instr_op = rrse_pkg::RRSE_OP_ROT_LEFT;
      instr_dest = 1'b1;
      repeat (6) begin
         @(negedge clk);
         `CHK("parked", {2'b10, m_pc}, {asleep, instr_ready, pc})
      end
      {wake_event, instr_valid} = 2'b10;
      @(negedge clk);
      wake_event = 1'b0;
      `CHK("woken", {2'b01, m_pc, 2'b01}, {asleep, instr_ready, pc, power_down_flag,
         expiry_flag})
      $display("test sleep done");
      // second reset brings both status flags back to 1
      do_reset();
      $display("test second reset done");
      finish_test();
   end
endmodule // rrse_exec_bench

`default_nettype wire
